// ===== design/csbh_pkg.sv
/*
  Package for the control and status byte handshake of a three-channel
  power measurement terminal: field positions, register numbers, reset
  values, mode encoding and the energy save timing.
  Assumes nothing of its surroundings; every design file imports it.
*/
package csbh_pkg;

  // ************************************************************
  // Widths and types
  // ************************************************************
  localparam int BYTE_W       = 8;
  localparam int WORD_W       = 16;
  localparam int REGNO_W      = 6;
  localparam int NUM_CHANNELS = 3;
  localparam int REG_COUNT    = 64;

  typedef logic [BYTE_W-1:0]  csbh_byte_t;
  typedef logic [WORD_W-1:0]  csbh_word_t;
  typedef logic [REGNO_W-1:0] csbh_regno_t;
  typedef logic [1:0]         csbh_chan_t;
  typedef logic [3:0]         csbh_idx_t;

  // Operating mode of one channel handshake.
  typedef enum logic [0:0]
  {
    MODE_PROCESS  = 1'b0,
    MODE_REGISTER = 1'b1
  } csbh_mode_t;

  // ************************************************************
  // Control and status byte fields
  // ************************************************************
  localparam int CB_REG_ACCESS_BIT = 7;
  localparam int CB_WRITE_BIT      = 6;
  localparam int CB_REGNO_MSB      = 5;
  localparam int CB_CHAN_MSB       = 5;
  localparam int CB_CHAN_LSB       = 4;
  localparam int CB_IDX_MSB        = 3;

  localparam csbh_chan_t CHAN_RESERVED = 2'h3;
  localparam csbh_chan_t CHAN_FIRST    = 2'h0;

  // ************************************************************
  // Register numbers, fields and reset values
  // ************************************************************
  localparam csbh_regno_t REG_DIAG      = 6'h06;
  localparam csbh_regno_t REG_FEATURE   = 6'h20;
  localparam csbh_regno_t REG_THRESHOLD = 6'h24;
  localparam int          FEATURE_FLEX_BIT = 3;

  localparam csbh_word_t  REG_RESET    = 16'h0000;
  localparam csbh_word_t  WORD_RESET   = 16'h0000;
  localparam csbh_byte_t  STATUS_RESET = 8'h00;
  localparam csbh_regno_t REGNO_RESET  = 6'h00;
  localparam csbh_idx_t   IDX_RESET    = 4'h0;

  // ************************************************************
  // Energy save timing
  // ************************************************************
  localparam int SAVE_CNT_W      = 40;
  localparam int CLOCK_HZ        = 25_000_000;
  localparam int SAVE_PERIOD_MIN = 15;
  localparam int SECONDS_PER_MIN = 60;
  localparam logic [SAVE_CNT_W-1:0] SAVE_PERIOD_CYCLES =
    SAVE_CNT_W'(SAVE_PERIOD_MIN) * SAVE_CNT_W'(SECONDS_PER_MIN) * SAVE_CNT_W'(CLOCK_HZ);
  localparam logic [SAVE_CNT_W-1:0] SAVE_CNT_ZERO = 40'h00_0000_0000;
  localparam logic [SAVE_CNT_W-1:0] SAVE_CNT_ONE  = 40'h00_0000_0001;

endpackage

// ===== design/csbh_save_timer.sv
/*
  Periodic energy save timer: one pulse every save period of continuous
  operation.
  Assumes a free-running clock; the period count is shortened by the
  parameter in simulation.
*/
module csbh_save_timer
  import csbh_pkg::*;
#(
  parameter logic [csbh_pkg::SAVE_CNT_W-1:0] PERIOD_CYCLES = csbh_pkg::SAVE_PERIOD_CYCLES
)
(
  input  wire logic clock,
  input  wire logic reset,
  output logic      save_strobe
);

  // ************************************************************
  // Period counter
  // ************************************************************
  logic [SAVE_CNT_W-1:0] count_reg;
  logic [SAVE_CNT_W-1:0] count_next;
  logic                  wrap_w;
  logic                  strobe_reg;

  // The counter wraps after exactly PERIOD_CYCLES clocks.
  assign wrap_w     = (count_reg == PERIOD_CYCLES - SAVE_CNT_ONE);
  assign count_next = wrap_w ? SAVE_CNT_ZERO : count_reg + SAVE_CNT_ONE;

  // A save pulse is issued once per full period, never at reset release.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      count_reg  <= SAVE_CNT_ZERO;
      strobe_reg <= 1'b0;
    end
    else
    begin
      count_reg  <= count_next;
      strobe_reg <= wrap_w;
    end
  end

  assign save_strobe = strobe_reg;

endmodule

// ===== design/csbh_top.sv
/*
  Control and status byte handshake of a three-channel power measurement
  terminal. Each channel takes a control byte and an output data word from
  the controller and returns a status byte and an input data word. In
  process data mode a measured value is selected and returned; in register
  communication mode a numbered register of the channel is read or written.
  Assumes the control bytes and output words are synchronous to clock and
  that the measurement engine answers a value selection combinationally
  within the same cycle.

*/
module csbh_top
  import csbh_pkg::*;
#(
  parameter logic [csbh_pkg::SAVE_CNT_W-1:0] SAVE_CYCLES = csbh_pkg::SAVE_PERIOD_CYCLES
)
(
  input  wire logic                 clock,
  input  wire logic                 reset,
  input  wire csbh_pkg::csbh_byte_t first_control_byte,
  input  wire csbh_pkg::csbh_byte_t second_control_byte,
  input  wire csbh_pkg::csbh_byte_t third_control_byte,
  input  wire csbh_pkg::csbh_word_t output_word_one,
  input  wire csbh_pkg::csbh_word_t output_word_two,
  input  wire csbh_pkg::csbh_word_t output_word_three,
  input  wire csbh_pkg::csbh_word_t phase_voltage_one,
  input  wire csbh_pkg::csbh_word_t phase_voltage_two,
  input  wire csbh_pkg::csbh_word_t phase_voltage_three,
  input  wire csbh_pkg::csbh_word_t value_data_one,
  input  wire csbh_pkg::csbh_word_t value_data_two,
  input  wire csbh_pkg::csbh_word_t value_data_three,
  output csbh_pkg::csbh_chan_t      value_select_channel_one,
  output csbh_pkg::csbh_chan_t      value_select_channel_two,
  output csbh_pkg::csbh_chan_t      value_select_channel_three,
  output csbh_pkg::csbh_idx_t       value_select_index_one,
  output csbh_pkg::csbh_idx_t       value_select_index_two,
  output csbh_pkg::csbh_idx_t       value_select_index_three,
  output csbh_pkg::csbh_byte_t      first_status_byte,
  output csbh_pkg::csbh_byte_t      second_status_byte,
  output csbh_pkg::csbh_byte_t      third_status_byte,
  output csbh_pkg::csbh_word_t      input_word_one,
  output csbh_pkg::csbh_word_t      input_word_two,
  output csbh_pkg::csbh_word_t      input_word_three,
  output logic                      phase_one_undervoltage_flag,
  output logic                      phase_two_undervoltage_flag,
  output logic                      phase_three_undervoltage_flag,
  output logic                      energy_save_strobe
);

  // ************************************************************
  // Status byte builders
  // ************************************************************

  // Status byte while process data is served.
  function automatic csbh_byte_t proc_status(input logic       uv,
                                             input csbh_chan_t chan,
                                             input csbh_idx_t  idx);
    proc_status = {1'b0, uv, chan, idx};
  endfunction

  // Status byte while a register access is acknowledged.
  function automatic csbh_byte_t reg_status(input logic        wr,
                                            input csbh_regno_t regno);
    reg_status = {1'b1, wr, regno};
  endfunction

  // ************************************************************
  // Per-channel port gathering
  // ************************************************************
  csbh_byte_t cb_w      [NUM_CHANNELS];
  csbh_word_t wdata_w   [NUM_CHANNELS];
  csbh_word_t volt_w    [NUM_CHANNELS];
  csbh_word_t vdata_w   [NUM_CHANNELS];
  csbh_chan_t sel_ch_w  [NUM_CHANNELS];
  csbh_idx_t  sel_idx_w [NUM_CHANNELS];
  csbh_byte_t status_w  [NUM_CHANNELS];
  csbh_word_t word_w    [NUM_CHANNELS];
  logic       uv_w      [NUM_CHANNELS];
  logic       flex_w;

  // The second and third channels copy the first but for their own channel code; only the first holds the flexible image switch.
  // common control layout
  assign cb_w[0]    = first_control_byte;
  assign cb_w[1]    = second_control_byte;
  assign cb_w[2]    = third_control_byte;
  assign wdata_w[0] = output_word_one;
  assign wdata_w[1] = output_word_two;
  assign wdata_w[2] = output_word_three;
  assign volt_w[0]  = phase_voltage_one;
  assign volt_w[1]  = phase_voltage_two;
  assign volt_w[2]  = phase_voltage_three;
  assign vdata_w[0] = value_data_one;
  assign vdata_w[1] = value_data_two;
  assign vdata_w[2] = value_data_three;

  // Outputs are flop-driven inside each channel slice.
  // common status layout
  assign first_status_byte          = status_w[0];
  assign second_status_byte         = status_w[1];
  assign third_status_byte          = status_w[2];
  assign input_word_one             = word_w[0];
  assign input_word_two             = word_w[1];
  assign input_word_three           = word_w[2];
  assign value_select_channel_one   = sel_ch_w[0];
  assign value_select_channel_two   = sel_ch_w[1];
  assign value_select_channel_three = sel_ch_w[2];
  assign value_select_index_one     = sel_idx_w[0];
  assign value_select_index_two     = sel_idx_w[1];
  assign value_select_index_three   = sel_idx_w[2];

  // The error indicators follow the sticky-free compare flops directly.
  // error indicator drive
  assign phase_one_undervoltage_flag   = uv_w[0];
  assign phase_two_undervoltage_flag   = uv_w[1];
  assign phase_three_undervoltage_flag = uv_w[2];

  // ************************************************************
  // Channel slices
  // ************************************************************
  genvar c;
  generate
    for (c = 0; c < NUM_CHANNELS; c++)
    begin : chan
      localparam csbh_chan_t OWN_CHAN = csbh_chan_t'(c);

      csbh_word_t  regs_reg [REG_COUNT];
      csbh_mode_t  mode_reg;
      csbh_mode_t  mode_next;
      logic        wr_reg;
      csbh_regno_t regno_reg;
      csbh_word_t  wdata_reg;
      csbh_chan_t  sel_ch_reg;
      csbh_chan_t  sel_ch_next;
      csbh_idx_t   sel_idx_reg;
      logic        flex_reg;
      logic        uv_reg;
      logic        uv_next;
      csbh_byte_t  status_reg;
      csbh_byte_t  status_next;
      csbh_word_t  word_reg;
      csbh_word_t  word_next;
      csbh_word_t  read_data;
      csbh_chan_t  req_ch;
      csbh_chan_t  rep_ch;
      logic        do_write;

      // The flexible image switch lives in the first channel's feature register.
      if (c == 0)
      begin : flex_src
        assign flex_w = regs_reg[REG_FEATURE][FEATURE_FLEX_BIT];
      end

      // Control bit 7 alone picks the mode; clearing it falls back at once.
      // leave register mode
      assign mode_next = cb_w[c][CB_REG_ACCESS_BIT] ? MODE_REGISTER : MODE_PROCESS;

      // Reserved channel code 11 selects the own channel rather than nothing.
      // fixed own channel
      assign req_ch      = cb_w[c][CB_CHAN_MSB:CB_CHAN_LSB];
      assign sel_ch_next = (flex_w && (req_ch != CHAN_RESERVED)) ? req_ch : OWN_CHAN;

      // A voltage equal to the threshold counts as healthy.
      // undervoltage compare
      assign uv_next = (volt_w[c] < regs_reg[REG_THRESHOLD]);

      // The diagnostic register shows live state and cannot be written.
      assign read_data = (regno_reg == REG_DIAG) ? {{(WORD_W-1){1'b0}}, uv_reg} : regs_reg[regno_reg];

      assign do_write = (mode_reg == MODE_REGISTER) && wr_reg && (regno_reg != REG_DIAG);

      // Channel bits read zero unless the flexible image is on.
      // inactive channel bits
      assign rep_ch = flex_reg ? sel_ch_reg : CHAN_FIRST;

      // Second stage: build the answer from the captured request.
      always_comb
      begin
        status_next = STATUS_RESET;
        word_next   = WORD_RESET;
        case (mode_reg)
          MODE_REGISTER:
          begin
            status_next = reg_status(wr_reg, regno_reg);
            word_next   = read_data;
          end
          MODE_PROCESS:
          begin
            status_next = proc_status(uv_reg, rep_ch, sel_idx_reg);
            word_next   = vdata_w[c];
          end
          default:
          begin
            status_next = STATUS_RESET;
            word_next   = WORD_RESET;
          end
        endcase
      end

      // First stage: capture the request and drive the value selection.
      always_ff @(posedge clock or posedge reset)
      begin
        if (reset)
        begin
          mode_reg    <= MODE_PROCESS;
          wr_reg      <= 1'b0;
          regno_reg   <= REGNO_RESET;
          wdata_reg   <= WORD_RESET;
          sel_ch_reg  <= CHAN_FIRST;
          sel_idx_reg <= IDX_RESET;
          flex_reg    <= 1'b0;
          uv_reg      <= 1'b0;
        end
        else
        begin
          mode_reg    <= mode_next;
          wr_reg      <= cb_w[c][CB_WRITE_BIT];
          regno_reg   <= cb_w[c][CB_REGNO_MSB:0];
          wdata_reg   <= wdata_w[c];
          sel_ch_reg  <= sel_ch_next;
          sel_idx_reg <= cb_w[c][CB_IDX_MSB:0];
          flex_reg    <= flex_w;
          uv_reg      <= uv_next;
        end
      end

      // Answer registers; data outputs come straight from these flops.
      always_ff @(posedge clock or posedge reset)
      begin
        if (reset)
        begin
          status_reg <= STATUS_RESET;
          word_reg   <= WORD_RESET;
        end
        else
        begin
          status_reg <= status_next;
          word_reg   <= word_next;
        end
      end

      // A held write rewrites the same value each cycle, which is harmless.
      always_ff @(posedge clock or posedge reset)
      begin
        if (reset)
        begin
          for (int i = 0; i < REG_COUNT; i++)
          begin
            regs_reg[i] <= REG_RESET;
          end
        end
        else if (do_write)
        begin
          regs_reg[regno_reg] <= wdata_reg;
        end
      end

      assign status_w[c]  = status_reg;
      assign word_w[c]    = word_reg;
      assign sel_ch_w[c]  = sel_ch_reg;
      assign sel_idx_w[c] = sel_idx_reg;
      assign uv_w[c]      = uv_reg;
    end
  endgenerate

  // ************************************************************
  // Energy save scheduling
  // ************************************************************

  // The strobe tells the storage controller to copy the energy counter.
  // periodic energy save
  csbh_save_timer #(
    .PERIOD_CYCLES (SAVE_CYCLES)
  ) u_save_timer (
    .clock       (clock),
    .reset       (reset),
    .save_strobe (energy_save_strobe)
  );

endmodule

// ===== testbench/csbh_chk.sv
/*
  Port checker for csbh_top: handshake timing, status layout and save timer.
  Assumes binding to csbh_top and the two-edge answer latency of the design.
*/
module csbh_chk
  import csbh_pkg::*;
#(
  parameter logic [csbh_pkg::SAVE_CNT_W-1:0] SAVE_CYCLES = csbh_pkg::SAVE_PERIOD_CYCLES
)
(
  input wire logic                 clock,
  input wire logic                 reset,
  input wire csbh_pkg::csbh_byte_t first_control_byte,
  input wire csbh_pkg::csbh_byte_t second_control_byte,
  input wire csbh_pkg::csbh_byte_t third_control_byte,
  input wire csbh_pkg::csbh_byte_t first_status_byte,
  input wire csbh_pkg::csbh_byte_t second_status_byte,
  input wire csbh_pkg::csbh_byte_t third_status_byte,
  input wire csbh_pkg::csbh_idx_t  value_select_index_one,
  input wire csbh_pkg::csbh_chan_t value_select_channel_two,
  input wire logic                 energy_save_strobe
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [1:0]            up_cnt;
  logic                  up;
  logic [SAVE_CNT_W-1:0] gap_cnt;
  logic                  seen;

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  // The pipeline still holds reset values for three edges, so wait them out.
  assign up = (up_cnt == 2'h3);

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      up_cnt <= 2'h0;
    else if (!up)
      up_cnt <= up_cnt + 2'h1;
  end

  // Cycles since the last save pulse.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      gap_cnt <= '0;
    else if (energy_save_strobe)
      gap_cnt <= '0;
    else
      gap_cnt <= gap_cnt + 1'b1;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      seen <= 1'b0;
    else if (energy_save_strobe)
      seen <= 1'b1;
  end

  // ****************************************
  // Assertions
  // ****************************************
  chk_proc_ack: assert property (!$past(first_control_byte[7], 2) |-> !first_status_byte[7])
    else $error("process status bit 7 not low");
  chk_reg_echo: assert property (up && $past(first_control_byte[7], 2)
    |-> first_status_byte == {1'b1, $past(first_control_byte[6:0], 2)}) else $error("register echo wrong");
  chk_reg_echo_two: assert property (up && $past(second_control_byte[7], 2)
    |-> second_status_byte == {1'b1, $past(second_control_byte[6:0], 2)}) else $error("second echo wrong");
  chk_leave_reg: assert property (up && $fell(first_control_byte[7]) |-> ##2 !first_status_byte[7])
    else $error("register mode not left");
  chk_idx_echo: assert property (up && !first_control_byte[7]
    |-> ##2 (first_status_byte[3:0] == $past(first_control_byte[3:0], 2))) else $error("index echo wrong");
  chk_chan_code: assert property (up && !$past(third_control_byte[7], 2)
    |-> third_status_byte[5:4] != CHAN_RESERVED) else $error("reserved channel code shown");
  chk_sel_index: assert property (up |-> value_select_index_one == $past(first_control_byte[3:0]))
    else $error("select index wrong");
  chk_sel_chan: assert property (value_select_channel_two != CHAN_RESERVED)
    else $error("reserved channel selected");
  chk_save_pulse: assert property (energy_save_strobe |=> !energy_save_strobe)
    else $error("save pulse too long");
  chk_save_period: assert property (energy_save_strobe && seen |-> gap_cnt == SAVE_CYCLES - 1'b1)
    else $error("save period wrong");

  cov_reg: cover property (up && first_status_byte[7]);
  cov_uv: cover property (up && first_status_byte[6]);
  cov_save: cover property (seen && energy_save_strobe);
endmodule

bind csbh_top csbh_chk #(.SAVE_CYCLES(SAVE_CYCLES)) u_chk (.clock, .reset, .first_control_byte,
  .second_control_byte, .third_control_byte, .first_status_byte, .second_status_byte,
  .third_status_byte, .value_select_index_one, .value_select_channel_two, .energy_save_strobe);

// ===== testbench/csbh_engine_model.sv
/*
  Measurement engine model: answers the value selection of each of the
  three channels within the same cycle.
  Assumes the selects come from csbh_top and settle before the next edge.
*/
module csbh_engine_model
  import csbh_pkg::*;
(
  input  wire csbh_pkg::csbh_chan_t sel_chan   [3],
  input  wire csbh_pkg::csbh_idx_t  sel_idx    [3],
  output csbh_pkg::csbh_word_t      value_data [3]
);
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // Value answer
  // ****************************************
  // Each word carries port, channel and index, so a misrouted value is seen at once.
  for (genvar p = 0; p < NUM_CHANNELS; p++)
  begin : g_ans
    assign value_data[p] = {4'ha, 2'(p), sel_chan[p], 4'h5, sel_idx[p]};
  end
endmodule

// ===== testbench/tb_control_status_byte_handshake.sv
/*
  Self-checking bench for the control and status byte handshake.
  Assumes csbh_top, the engine model and the bound checker are compiled.
*/
module tb_control_status_byte_handshake;
  import csbh_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int SAVE = 20;

  logic       clock = 1'b0;
  logic       reset = 1'b1;
  csbh_byte_t ctl [3];
  csbh_byte_t sts [3];
  csbh_word_t ow  [3];
  csbh_word_t pv  [3];
  csbh_word_t vd  [3];
  csbh_word_t iw  [3];
  csbh_chan_t vsc [3];
  csbh_idx_t  vsi [3];
  logic [2:0] uv;
  logic       save;
  int         fails = 0;
  int         n_compared = 0;

  always #20 clock = ~clock;

  csbh_top #(.SAVE_CYCLES(40'(SAVE))) u_dut (.clock(clock), .reset(reset),
    .first_control_byte(ctl[0]), .second_control_byte(ctl[1]), .third_control_byte(ctl[2]),
    .output_word_one(ow[0]), .output_word_two(ow[1]), .output_word_three(ow[2]),
    .phase_voltage_one(pv[0]), .phase_voltage_two(pv[1]), .phase_voltage_three(pv[2]),
    .value_data_one(vd[0]), .value_data_two(vd[1]), .value_data_three(vd[2]),
    .value_select_channel_one(vsc[0]), .value_select_channel_two(vsc[1]),
    .value_select_channel_three(vsc[2]), .value_select_index_one(vsi[0]),
    .value_select_index_two(vsi[1]), .value_select_index_three(vsi[2]),
    .first_status_byte(sts[0]), .second_status_byte(sts[1]), .third_status_byte(sts[2]),
    .input_word_one(iw[0]), .input_word_two(iw[1]), .input_word_three(iw[2]),
    .phase_one_undervoltage_flag(uv[0]), .phase_two_undervoltage_flag(uv[1]),
    .phase_three_undervoltage_flag(uv[2]), .energy_save_strobe(save));

  csbh_engine_model u_eng (.sel_chan(vsc), .sel_idx(vsi), .value_data(vd));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Drive at a falling edge; the answer has settled two rising edges later.
  task automatic step(input int ch, input csbh_byte_t c, input csbh_word_t w);
    @(negedge clock);
    ctl[ch] = c;
    ow[ch] = w;
    repeat (2) @(negedge clock);
  endtask

  function automatic csbh_word_t ev(input int p, input int c, input int i);
    return {4'ha, 2'(p), 2'(c), 4'h5, 4'(i)};
  endfunction

  task automatic wr(input int ch, input csbh_regno_t n, input csbh_word_t v);
    step(ch, {2'b11, n}, v);
    chk(16'(sts[ch]), 16'({2'b11, n}));
  endtask

  task automatic rd(input int ch, input csbh_regno_t n, input csbh_word_t v);
    step(ch, {2'b10, n}, 16'h0000);
    chk(16'(sts[ch]), 16'({2'b10, n}));
    chk(iw[ch], v);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  // Every index on all three channels at once, simple image.
  task automatic t_proc();
    for (int i = 0; i < 16; i++)
    begin
      @(negedge clock);
      foreach (ctl[c]) ctl[c] = 8'(i);
      repeat (2) @(negedge clock);
      foreach (ctl[c])
      begin
        chk(16'(sts[c]), 16'(i));
        chk(iw[c], ev(c, c, i));
      end
    end
  endtask

  task automatic t_reg();
    rd(0, REG_THRESHOLD, 16'h0000);
    wr(0, REG_THRESHOLD, 16'h0100);
    rd(0, REG_THRESHOLD, 16'h0100);
    wr(1, 6'h11, 16'hbeef);
    rd(1, 6'h11, 16'hbeef);
    wr(2, 6'h3f, 16'h5a5a);
    rd(2, 6'h3f, 16'h5a5a);
    wr(0, REG_DIAG, 16'h1234);
    rd(0, REG_DIAG, 16'h0000);
  endtask

  // Below, equal to and above the threshold of 0x0100.
  task automatic t_uv();
    csbh_word_t v [3] = '{16'h0050, 16'h0100, 16'h0200};
    for (int k = 0; k < 3; k++)
    begin
      @(negedge clock);
      pv[0] = v[k];
      step(0, 8'h01, 16'h0000);
      chk(16'(sts[0]), (k == 0) ? 16'h0041 : 16'h0001);
      chk(16'(uv), (k == 0) ? 16'h0001 : 16'h0000);
    end
    pv[0] = 16'h1000;
  endtask

  // All channel codes with the flexible image off, then on.
  task automatic t_flex();
    int e;
    for (int f = 0; f < 2; f++)
    begin
      wr(0, REG_FEATURE, (f == 1) ? 16'h0008 : 16'h0000);
      for (int c = 0; c < 4; c++)
      begin
        e = (f == 0 || c == 3) ? 0 : c;
        step(0, {2'b00, 2'(c), 4'h1}, 16'h0000);
        chk(16'(sts[0]), 16'({2'b00, 2'(e), 4'h1}));
        chk(iw[0], ev(0, e, 1));
      end
    end
    wr(0, REG_FEATURE, 16'h0000);
  endtask

  // Register access followed at once by a process request.
  task automatic t_mode();
    @(negedge clock);
    ctl[0] = 8'h8a;
    @(negedge clock);
    ctl[0] = 8'h02;
    @(negedge clock);
    chk(16'(sts[0]), 16'h008a);
    chk(iw[0], 16'h0000);
    @(negedge clock);
    chk(16'(sts[0]), 16'h0002);
    chk(iw[0], ev(0, 0, 2));
  endtask

  task automatic t_save();
    int n;
    n = 0;
    while (save !== 1'b1 && n < 100)
    begin
      @(negedge clock);
      n++;
    end
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
    end
    while (save !== 1'b1 && n < 100);
    chk(16'(n), 16'(SAVE));
  endtask

  task automatic test_done();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial
  begin
    foreach (ctl[i])
    begin
      ctl[i] = 8'h00;
      ow[i] = 16'h0000;
      pv[i] = 16'h1000;
    end
    repeat (6) @(posedge clock);
    @(negedge clock);
    chk(16'(sts[0]), 16'h0000);
    chk(iw[0], 16'h0000);
    reset = 1'b0;
    t_proc();
    t_reg();
    t_uv();
    t_flex();
    t_mode();
    t_save();
    test_done();
  end

  // Generous against about 170 cycles of scenarios.
  initial
  begin
    #(4000 * 40);
    fails++;
    test_done();
  end
endmodule
